/* hw/pcrw_map.vh */
// register map, field positions and reset values of the port layer
`ifndef PCRW_MAP_VH
`define PCRW_MAP_VH
`define PCRW_AXI_AW 18
`define PCRW_AXI_WORD_LSB 2
`define PCRW_CPU_MSB 17
`define PCRW_BASE_MSB 15
`define PCRW_BASE_LSB 11
`define PCRW_BLK_MSB 10
`define PCRW_BLK_LSB 9
`define PCRW_OFS_MSB 8
`define PCRW_BLK_FREE 2'h0
`define PCRW_REGISTER_BASE_INIT_BASE_MSB 7
`define PCRW_REGISTER_BASE_INIT_BASE_LSB 3
`define PCRW_OFS_A_DATA 9'h000
`define PCRW_OFS_B_DATA 9'h001
`define PCRW_OFS_A_DIR 9'h002
`define PCRW_OFS_B_DIR 9'h003
`define PCRW_OFS_E_DATA 9'h008
`define PCRW_OFS_E_DIR 9'h009
`define PCRW_OFS_E_ASSIGN 9'h00A
`define PCRW_OFS_MODE 9'h00B
`define PCRW_OFS_PULL 9'h00C
`define PCRW_OFS_RDRV 9'h00D
`define PCRW_OFS_BASE 9'h011
`define PCRW_OFS_PWM_CTL 9'h054
`define PCRW_OFS_P_DATA 9'h056
`define PCRW_OFS_P_DIR 9'h057
`define PCRW_OFS_AD_DATA 9'h06F
`define PCRW_OFS_TMR2 9'h08D
`define PCRW_OFS_T_DATA 9'h0AE
`define PCRW_OFS_T_DIR 9'h0AF
`define PCRW_OFS_S_DATA 9'h0D6
`define PCRW_OFS_S_DIR 9'h0D7
`define PCRW_OFS_S_PD 9'h0DB
`define PCRW_OFS_L_CTL 9'h0FD
`define PCRW_OFS_L_DATA 9'h0FE
`define PCRW_OFS_L_DIR 9'h0FF
`define PCRW_MASK_E_DIR 8'hFC
`define PCRW_MASK_E_ASSIGN 8'hBC
`define PCRW_MASK_PULL 8'h13
`define PCRW_MASK_RDRV 8'h0B
`define PCRW_MASK_BASE 8'hF8
`define PCRW_MASK_PWM_CTL 8'h1F
`define PCRW_MASK_TMR2 8'hBF
`define PCRW_MASK_S_PD 8'h77
`define PCRW_MASK_L_CTL 8'h03
`define PCRW_MASK_L_PINS 8'h7F
`define PCRW_MASK_E_IN 8'h03
`define PCRW_RST_ZERO 8'h00
`define PCRW_RST_PULL 8'h10
`define PCRW_RST_BASE 8'h00
`define PCRW_PULL_ENABLE_A 0
`define PCRW_PULL_ENABLE_B 1
`define PCRW_PULL_ENABLE_CONTROL_PORT 4
`define PCRW_LOW_DRIVE_A 0
`define PCRW_LOW_DRIVE_B 1
`define PCRW_LOW_DRIVE_CONTROL_PORT 3
`define PCRW_PUPP 1
`define PCRW_RDPP 2
`define PCRW_PUPT 5
`define PCRW_RDPT 4
`define PCRW_PUPS0 0
`define PCRW_PUPS1 1
`define PCRW_PUPS2 2
`define PCRW_RDPS0 4
`define PCRW_RDPS1 5
`define PCRW_RDPS2 6
`define PCRW_L_PULL 0
`define PCRW_L_RDRV 1
`define PCRW_MODE_SHIFT 5
`define PCRW_MODE_SINGLE 2'h0
`define PCRW_MODE_PERIPH 2'h3
`define PCRW_STRAP_WAIT 2'h3
`define PCRW_RESP_OKAY 2'h0
`define PCRW_RESP_DECERR 2'h3
`endif

/* hw/pcrw_pin_port.v */
// one port of pins: input synchroniser, direction, takeover, pull and drive
`timescale 1ns/1ps
`default_nettype none
module pcrw_pin_port #(
	parameter W = 8
) (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// pins
	input wire [W-1:0] pin_in,
	output reg [W-1:0] pin_out_reg,
	output reg [W-1:0] pin_oe_reg,
	output reg [W-1:0] pull_on_reg,
	output reg [W-1:0] low_drive_reg,
	output reg [W-1:0] level_reg,
	// control from the register file and peripherals
	input wire [W-1:0] dir,
	input wire [W-1:0] data,
	input wire [W-1:0] claim,
	input wire [W-1:0] alt_out,
	input wire [W-1:0] alt_oe,
	input wire [W-1:0] pull_en,
	input wire [W-1:0] low_en
);
	reg [W-1:0] sync1_reg;
	reg [W-1:0] sync2_reg;
	reg [W-1:0] sync3_reg;
	wire [W-1:0] drive_next;
	wire [W-1:0] value_next;
	wire [W-1:0] agree;

	// a peripheral that claims a pin overrides the general-purpose path
	assign drive_next = (claim & alt_oe) | (~claim & dir);
	assign value_next = (claim & alt_out) | (~claim & data);
	assign agree = ~(sync2_reg ^ sync3_reg);

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= {W{1'b0}};
			sync2_reg <= {W{1'b0}};
			sync3_reg <= {W{1'b0}};
			level_reg <= {W{1'b0}};
			pin_out_reg <= {W{1'b0}};
			pin_oe_reg <= {W{1'b0}};
			pull_on_reg <= {W{1'b0}};
			low_drive_reg <= {W{1'b0}};
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= (agree & sync2_reg) | (~agree & level_reg);
			pin_out_reg <= value_next;
			pin_oe_reg <= drive_next;
			// pull-ups only act on pins that are not driven
			pull_on_reg <= pull_en & ~drive_next;
			low_drive_reg <= low_en;
		end
	end
endmodule
`default_nettype wire

/* hw/pcrw_top.v */
// port layer and relocatable register window behind an axi4-lite slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcrw_map.vh"
module pcrw_top #(
	parameter NPORT = 8,
	parameter PW = 8
) (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// axi4-lite write channels
	input wire [`PCRW_AXI_AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read channels
	input wire [`PCRW_AXI_AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// pins: a b e p t s link ad, eight bits each
	input wire [NPORT*PW-1:0] port_pin_in,
	output wire [NPORT*PW-1:0] port_pin_out,
	output wire [NPORT*PW-1:0] port_pin_oe,
	output wire [NPORT*PW-1:0] port_pull_on,
	output wire [NPORT*PW-1:0] port_low_drive,
	output wire [NPORT*PW-1:0] port_level,
	// mode strap and captured mode
	input wire [1:0] mode_pins,
	output reg [1:0] op_mode_reg,
	// peripheral functions sharing the pins
	input wire [15:0] bus_out,
	input wire [15:0] bus_oe,
	input wire [7:0] ctrl_fn_out,
	input wire [7:0] ctrl_fn_oe,
	input wire [3:0] pwm_chan_en,
	input wire [3:0] pwm_chan_out,
	input wire [7:0] timer_claim,
	input wire [7:0] timer_out,
	input wire [7:0] timer_oe,
	input wire [7:0] serial_claim,
	input wire [7:0] serial_out,
	input wire [7:0] serial_oe,
	input wire link_enable,
	input wire [6:0] link_out,
	input wire [6:0] link_oe
);
	// register file
	reg [7:0] a_data_reg;
	reg [7:0] b_data_reg;
	reg [7:0] a_dir_reg;
	reg [7:0] b_dir_reg;
	reg [7:0] e_data_reg;
	reg [7:0] e_dir_reg;
	reg [7:0] e_assign_reg;
	reg [7:0] pull_reg;
	reg [7:0] rdrv_reg;
	reg rdrv_done_reg;
	reg [7:0] base_reg;
	reg [7:0] pwm_ctl_reg;
	reg [7:0] p_data_reg;
	reg [7:0] p_dir_reg;
	reg [7:0] tmr2_reg;
	reg [7:0] t_data_reg;
	reg [7:0] t_dir_reg;
	reg [7:0] s_data_reg;
	reg [7:0] s_dir_reg;
	reg [7:0] s_pd_reg;
	reg [7:0] l_ctl_reg;
	reg [7:0] l_data_reg;
	reg [7:0] l_dir_reg;
	// strap capture
	reg [1:0] strap1_reg;
	reg [1:0] strap2_reg;
	reg [1:0] strap3_reg;
	reg [1:0] strap_cnt_reg;
	reg strap_done_reg;
	// axi holding state
	reg aw_full_reg;
	reg w_full_reg;
	reg [15:0] waddr_reg;
	reg [7:0] wbyte_reg;
	reg wlane_reg;
	reg aw_full_next;
	reg w_full_next;

	wire expanded;
	wire periph;
	wire ab_mapped;
	wire e_mapped;
	wire do_wr;
	wire wr_hit;
	wire [8:0] wr_ofs;
	wire [15:0] rd_addr;
	wire [7:0] wd;

	assign periph = (op_mode_reg == `PCRW_MODE_PERIPH);
	assign expanded = (op_mode_reg != `PCRW_MODE_SINGLE);
	assign ab_mapped = ~expanded;
	assign e_mapped = ~periph;

	// block hit: base match and inside the low 512 bytes of the region
	function in_block;
		input [15:0] a;
		begin
			in_block = (a[`PCRW_BASE_MSB:`PCRW_BASE_LSB] ==
				base_reg[`PCRW_REGISTER_BASE_INIT_BASE_MSB:`PCRW_REGISTER_BASE_INIT_BASE_LSB]) &&
				(a[`PCRW_BLK_MSB:`PCRW_BLK_LSB] == `PCRW_BLK_FREE);
		end
	endfunction

	// readback of a port data register: latch when output, pin when input
	function [7:0] port_view;
		input [7:0] dir;
		input [7:0] data;
		input [7:0] level;
		begin
			port_view = (dir & data) | (~dir & level);
		end
	endfunction

	// read multiplexer; unmapped or reserved locations give zero
	function [7:0] read_byte;
		input [8:0] ofs;
		begin
			read_byte = 8'h00;
			if (ofs == `PCRW_OFS_A_DATA) begin
				if (ab_mapped) read_byte = port_view(a_dir_reg, a_data_reg, port_level[7:0]);
			end else if (ofs == `PCRW_OFS_B_DATA) begin
				if (ab_mapped) read_byte = port_view(b_dir_reg, b_data_reg, port_level[15:8]);
			end else if (ofs == `PCRW_OFS_A_DIR) begin
				if (ab_mapped) read_byte = a_dir_reg;
			end else if (ofs == `PCRW_OFS_B_DIR) begin
				if (ab_mapped) read_byte = b_dir_reg;
			end else if (ofs == `PCRW_OFS_E_DATA) begin
				// input-only pins show their level regardless of function
				if (e_mapped) read_byte = port_view(e_dir_reg, e_data_reg, port_level[23:16]);
			end else if (ofs == `PCRW_OFS_E_DIR) begin
				if (e_mapped) read_byte = e_dir_reg;
			end else if (ofs == `PCRW_OFS_E_ASSIGN) begin
				read_byte = e_assign_reg;
			end else if (ofs == `PCRW_OFS_MODE) begin
				read_byte = {1'b0, op_mode_reg, 5'h00} ;
			end else if (ofs == `PCRW_OFS_PULL) begin
				read_byte = pull_reg;
			end else if (ofs == `PCRW_OFS_RDRV) begin
				if (e_mapped) read_byte = rdrv_reg;
			end else if (ofs == `PCRW_OFS_BASE) begin
				read_byte = base_reg;
			end else if (ofs == `PCRW_OFS_PWM_CTL) begin
				read_byte = pwm_ctl_reg;
			end else if (ofs == `PCRW_OFS_P_DATA) begin
				read_byte = port_view(p_dir_reg, p_data_reg, port_level[31:24]);
			end else if (ofs == `PCRW_OFS_P_DIR) begin
				read_byte = p_dir_reg;
			end else if (ofs == `PCRW_OFS_AD_DATA) begin
				read_byte = port_level[63:56];
			end else if (ofs == `PCRW_OFS_TMR2) begin
				read_byte = tmr2_reg;
			end else if (ofs == `PCRW_OFS_T_DATA) begin
				read_byte = port_view(t_dir_reg, t_data_reg, port_level[39:32]);
			end else if (ofs == `PCRW_OFS_T_DIR) begin
				read_byte = t_dir_reg;
			end else if (ofs == `PCRW_OFS_S_DATA) begin
				read_byte = port_view(s_dir_reg, s_data_reg, port_level[47:40]);
			end else if (ofs == `PCRW_OFS_S_DIR) begin
				read_byte = s_dir_reg;
			end else if (ofs == `PCRW_OFS_S_PD) begin
				read_byte = s_pd_reg;
			end else if (ofs == `PCRW_OFS_L_CTL) begin
				read_byte = l_ctl_reg;
			end else if (ofs == `PCRW_OFS_L_DATA) begin
				read_byte = port_view(l_dir_reg, l_data_reg, port_level[55:48]) &
					`PCRW_MASK_L_PINS;
			end else if (ofs == `PCRW_OFS_L_DIR) begin
				read_byte = l_dir_reg;
			end
		end
	endfunction

	// mode strap: three stages, caught once the last two agree after release
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			strap1_reg <= 2'h0;
			strap2_reg <= 2'h0;
			strap3_reg <= 2'h0;
			strap_cnt_reg <= 2'h0;
			strap_done_reg <= 1'b0;
			op_mode_reg <= `PCRW_MODE_SINGLE;
		end else begin
			strap1_reg <= mode_pins;
			strap2_reg <= strap1_reg;
			strap3_reg <= strap2_reg;
			if (strap_cnt_reg != `PCRW_STRAP_WAIT) begin
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
			end else if (!strap_done_reg && (strap2_reg == strap3_reg)) begin
				strap_done_reg <= 1'b1;
				op_mode_reg <= strap3_reg;
			end
		end
	end

	// axi write: address and data taken in either order, then one response
	assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign wr_hit = in_block(waddr_reg);
	assign wr_ofs = waddr_reg[`PCRW_OFS_MSB:0];
	assign wd = wbyte_reg;

	always @* begin
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		if (s_axi_awvalid && s_axi_awready) aw_full_next = 1'b1;
		if (s_axi_wvalid && s_axi_wready) w_full_next = 1'b1;
		if (do_wr) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
		end
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			waddr_reg <= 16'h0000;
			wbyte_reg <= 8'h00;
			wlane_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PCRW_RESP_OKAY;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			s_axi_awready <= ~aw_full_next;
			s_axi_wready <= ~w_full_next;
			if (s_axi_awvalid && s_axi_awready)
				waddr_reg <= s_axi_awaddr[`PCRW_CPU_MSB:`PCRW_AXI_WORD_LSB];
			if (s_axi_wvalid && s_axi_wready) begin
				wbyte_reg <= s_axi_wdata[7:0];
				wlane_reg <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `PCRW_RESP_OKAY : `PCRW_RESP_DECERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes; reserved and unmapped locations drop the data
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			a_data_reg <= `PCRW_RST_ZERO;
			b_data_reg <= `PCRW_RST_ZERO;
			a_dir_reg <= `PCRW_RST_ZERO;
			b_dir_reg <= `PCRW_RST_ZERO;
			e_data_reg <= `PCRW_RST_ZERO;
			e_dir_reg <= `PCRW_RST_ZERO;
			e_assign_reg <= `PCRW_RST_ZERO;
			pull_reg <= `PCRW_RST_PULL;
			rdrv_reg <= `PCRW_RST_ZERO;
			rdrv_done_reg <= 1'b0;
			base_reg <= `PCRW_RST_BASE;
			pwm_ctl_reg <= `PCRW_RST_ZERO;
			p_data_reg <= `PCRW_RST_ZERO;
			p_dir_reg <= `PCRW_RST_ZERO;
			tmr2_reg <= `PCRW_RST_ZERO;
			t_data_reg <= `PCRW_RST_ZERO;
			t_dir_reg <= `PCRW_RST_ZERO;
			s_data_reg <= `PCRW_RST_ZERO;
			s_dir_reg <= `PCRW_RST_ZERO;
			s_pd_reg <= `PCRW_RST_ZERO;
			l_ctl_reg <= `PCRW_RST_ZERO;
			l_data_reg <= `PCRW_RST_ZERO;
			l_dir_reg <= `PCRW_RST_ZERO;
		end else if (do_wr && wr_hit && wlane_reg) begin
			if (wr_ofs == `PCRW_OFS_A_DATA) begin
				if (ab_mapped) a_data_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_B_DATA) begin
				if (ab_mapped) b_data_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_A_DIR) begin
				if (ab_mapped) a_dir_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_B_DIR) begin
				if (ab_mapped) b_dir_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_E_DATA) begin
				if (e_mapped) e_data_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_E_DIR) begin
				if (e_mapped) e_dir_reg <= wd & `PCRW_MASK_E_DIR;
			end else if (wr_ofs == `PCRW_OFS_E_ASSIGN) begin
				e_assign_reg <= wd & `PCRW_MASK_E_ASSIGN;
			end else if (wr_ofs == `PCRW_OFS_PULL) begin
				pull_reg <= wd & `PCRW_MASK_PULL;
			end else if (wr_ofs == `PCRW_OFS_RDRV) begin
				if (e_mapped && !rdrv_done_reg) begin
					rdrv_reg <= wd & `PCRW_MASK_RDRV;
					rdrv_done_reg <= 1'b1;
				end
			end else if (wr_ofs == `PCRW_OFS_BASE) begin
				base_reg <= wd & `PCRW_MASK_BASE;
			end else if (wr_ofs == `PCRW_OFS_PWM_CTL) begin
				pwm_ctl_reg <= wd & `PCRW_MASK_PWM_CTL;
			end else if (wr_ofs == `PCRW_OFS_P_DATA) begin
				p_data_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_P_DIR) begin
				p_dir_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_TMR2) begin
				tmr2_reg <= wd & `PCRW_MASK_TMR2;
			end else if (wr_ofs == `PCRW_OFS_T_DATA) begin
				t_data_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_T_DIR) begin
				t_dir_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_S_DATA) begin
				s_data_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_S_DIR) begin
				s_dir_reg <= wd;
			end else if (wr_ofs == `PCRW_OFS_S_PD) begin
				s_pd_reg <= wd & `PCRW_MASK_S_PD;
			end else if (wr_ofs == `PCRW_OFS_L_CTL) begin
				l_ctl_reg <= wd & `PCRW_MASK_L_CTL;
			end else if (wr_ofs == `PCRW_OFS_L_DATA) begin
				l_data_reg <= wd & `PCRW_MASK_L_PINS;
			end else if (wr_ofs == `PCRW_OFS_L_DIR) begin
				l_dir_reg <= wd & `PCRW_MASK_L_PINS;
			end
		end
	end

	// axi read: one cycle from address handshake to data
	assign rd_addr = s_axi_araddr[`PCRW_CPU_MSB:`PCRW_AXI_WORD_LSB];

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PCRW_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			if (in_block(rd_addr)) begin
				s_axi_rdata <= {24'h000000, read_byte(rd_addr[`PCRW_OFS_MSB:0])};
				s_axi_rresp <= `PCRW_RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `PCRW_RESP_DECERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// per-pin control vectors, port slots a b e p t s link ad
	wire [7:0] e_claim;
	wire [7:0] e_pull;
	wire [NPORT*PW-1:0] dir_v;
	wire [NPORT*PW-1:0] data_v;
	wire [NPORT*PW-1:0] claim_v;
	wire [NPORT*PW-1:0] alt_out_v;
	wire [NPORT*PW-1:0] alt_oe_v;
	wire [NPORT*PW-1:0] pull_v;
	wire [NPORT*PW-1:0] low_v;

	// bus strobes take control pins only in expanded modes; irq pins stay inputs
	assign e_claim = expanded ? (e_assign_reg & `PCRW_MASK_E_ASSIGN) : 8'h00;
	// pin 1 always pulled by resistor, pins 7,3,2,0 by the enable
	assign e_pull = {pull_reg[`PCRW_PULL_ENABLE_CONTROL_PORT], 3'h0, {2{pull_reg[`PCRW_PULL_ENABLE_CONTROL_PORT]}}, 1'b1,
		pull_reg[`PCRW_PULL_ENABLE_CONTROL_PORT]};

	assign dir_v = {8'h00, l_dir_reg, s_dir_reg, t_dir_reg, p_dir_reg,
		e_dir_reg & `PCRW_MASK_E_DIR, b_dir_reg, a_dir_reg};
	assign data_v = {8'h00, l_data_reg, s_data_reg, t_data_reg, p_data_reg,
		e_data_reg, b_data_reg, a_data_reg};
	assign claim_v = {8'h00, 1'b0, {7{link_enable}},
		serial_claim,
		timer_claim,
		4'h0, pwm_chan_en,
		e_claim, {16{expanded}}};
	assign alt_out_v = {8'h00, 1'b0, link_out, serial_out, timer_out,
		4'h0, pwm_chan_out, ctrl_fn_out, bus_out};
	assign alt_oe_v = {8'h00, 1'b0, link_oe, serial_oe, timer_oe,
		4'h0, {4{1'b1}}, ctrl_fn_oe, bus_oe};
	assign pull_v = {8'h00, 1'b0, {7{l_ctl_reg[`PCRW_L_PULL]}},
		{4{s_pd_reg[`PCRW_PUPS2]}}, {2{s_pd_reg[`PCRW_PUPS1]}}, {2{s_pd_reg[`PCRW_PUPS0]}},
		{8{tmr2_reg[`PCRW_PUPT]}}, {8{pwm_ctl_reg[`PCRW_PUPP]}}, e_pull,
		{8{pull_reg[`PCRW_PULL_ENABLE_B] & ~expanded}},
		{8{pull_reg[`PCRW_PULL_ENABLE_A] & ~expanded}}};
	assign low_v = {8'h00, 1'b0, {7{l_ctl_reg[`PCRW_L_RDRV]}},
		{4{s_pd_reg[`PCRW_RDPS2]}}, {2{s_pd_reg[`PCRW_RDPS1]}}, {2{s_pd_reg[`PCRW_RDPS0]}},
		{8{tmr2_reg[`PCRW_RDPT]}}, {8{pwm_ctl_reg[`PCRW_RDPP]}},
		{8{rdrv_reg[`PCRW_LOW_DRIVE_CONTROL_PORT]}}, {8{rdrv_reg[`PCRW_LOW_DRIVE_B]}},
		{8{rdrv_reg[`PCRW_LOW_DRIVE_A]}}};

	genvar gi;
	generate
		for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
			pcrw_pin_port #(
				.W(PW)
			) u_port (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.pin_in(port_pin_in[gi*PW +: PW]),
				.pin_out_reg(port_pin_out[gi*PW +: PW]),
				.pin_oe_reg(port_pin_oe[gi*PW +: PW]),
				.pull_on_reg(port_pull_on[gi*PW +: PW]),
				.low_drive_reg(port_low_drive[gi*PW +: PW]),
				.level_reg(port_level[gi*PW +: PW]),
				.dir(dir_v[gi*PW +: PW]),
				.data(data_v[gi*PW +: PW]),
				.claim(claim_v[gi*PW +: PW]),
				.alt_out(alt_out_v[gi*PW +: PW]),
				.alt_oe(alt_oe_v[gi*PW +: PW]),
				.pull_en(pull_v[gi*PW +: PW]),
				.low_en(low_v[gi*PW +: PW])
			);
		end
	endgenerate
endmodule
`default_nettype wire

/* sim/pcrw_props.sv */
// assertions on the port layer top ports
`timescale 1ns/1ps
`default_nettype none
`include "pcrw_map.vh"
module pcrw_props #(
	parameter NPORT = 8,
	parameter PW = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [`PCRW_AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	// pins and peripherals
	input wire logic [NPORT*PW-1:0] port_pin_out,
	input wire logic [NPORT*PW-1:0] port_pin_oe,
	input wire logic [NPORT*PW-1:0] port_pull_on,
	input wire logic [1:0] op_mode_reg,
	input wire logic [15:0] bus_oe,
	input wire logic [3:0] pwm_chan_en,
	input wire logic [3:0] pwm_chan_out,
	input wire logic [7:0] timer_claim,
	input wire logic [7:0] timer_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_rd_out;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[12:11] != 2'h0
			|=> s_axi_rvalid && s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0;
	endproperty
	a_rd_out: assert property (p_rd_out) else $error("read outside block not refused");
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_rd_hi;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("unused read bits not zero");
	property p_ad_in;
		port_pin_oe[63:56] == 8'h00;
	endproperty
	a_ad_in: assert property (p_ad_in) else $error("analog port driven");
	property p_e_in;
		port_pin_oe[17:16] == 2'h0;
	endproperty
	a_e_in: assert property (p_e_in) else $error("input-only control pins driven");
	property p_pull;
		(port_pin_oe & port_pull_on) == '0;
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up on driven pin");
	property p_pwm;
		pwm_chan_en == 4'hF
			|=> port_pin_oe[27:24] == 4'hF && port_pin_out[27:24] == $past(pwm_chan_out);
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm pins not taken over");
	property p_timer;
		timer_claim == 8'hFF |=> port_pin_oe[39:32] == $past(timer_oe);
	endproperty
	a_timer: assert property (p_timer) else $error("timer pins not taken over");
	property p_exp;
		op_mode_reg == 2'h1
			|=> port_pin_oe[15:0] == $past(bus_oe) && port_pull_on[15:0] == 16'h0;
	endproperty
	a_exp: assert property (p_exp) else $error("bus ports not given to bus");
endmodule
`default_nettype wire

/* sim/pcrw_board.sv */
// board circuitry seen at the port pins
`timescale 1ns/1ps
`default_nettype none
module pcrw_board (
	// clock
	input wire logic sys_clk,
	// device side
	input wire logic [63:0] pin_out,
	input wire logic [63:0] pin_oe,
	input wire logic [63:0] pull_on,
	output wire logic [63:0] pin_in,
	// external drivers
	input wire logic [63:0] ext_val,
	input wire logic [63:0] ext_en
);
	logic [63:0] float_reg = 64'h0;
	// floating lines wander every cycle
	always @(posedge sys_clk)
		float_reg <= ~float_reg;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pull_on | float_reg));
endmodule
`default_nettype wire

/* sim/port_config_and_register_window_bench.sv */
// self-checking bench of the port layer
`timescale 1ns/1ps
`default_nettype none
`include "pcrw_map.vh"
module port_config_and_register_window_bench;
	logic sys_clk = 1'h0, nrst = 1'h0;
	logic [`PCRW_AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, link_enable = 1'h0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'hE3B42003;
	logic [3:0] s_axi_wstrb = 4'hF, pwm_chan_en = '0, pwm_chan_out = '0;
	logic [1:0] mode_pins = 2'h0, s_axi_bresp, s_axi_rresp, op_mode_reg;
	logic [15:0] bus_out = '0, bus_oe = '0;
	logic [7:0] ctrl_fn_out = '0, ctrl_fn_oe = '0, timer_claim = '0, timer_out = '0;
	logic [7:0] timer_oe = '0, serial_claim = '0, serial_out = '0, serial_oe = '0, v;
	logic [6:0] link_out = '0, link_oe = '0;
	logic [63:0] bd_val = '0, bd_en = '0, port_pin_in, port_pin_out, port_pin_oe, port_pull_on;
	logic [63:0] port_low_drive;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [15:0] ix [10] = '{16'h09, 16'h0A, 16'h0C, 16'h54, 16'h8D, 16'hDB, 16'hFD, 16'hFF,
		16'h04, 16'h0E};
	logic [7:0] mk [10] = '{8'hFC, 8'hBC, 8'h13, 8'h1F, 8'hBF, 8'h77, 8'h03, 8'h7F, 8'h00, 8'h00};
	int errors = 0, cmp_count = 0;
	pcrw_top u_dut (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_pin_in, .port_pin_out, .port_pin_oe,
		.port_pull_on, .port_low_drive, .port_level(), .mode_pins, .op_mode_reg, .bus_out,
		.bus_oe, .ctrl_fn_out, .ctrl_fn_oe, .pwm_chan_en, .pwm_chan_out, .timer_claim,
		.timer_out, .timer_oe, .serial_claim, .serial_out, .serial_oe, .link_enable,
		.link_out, .link_oe);
	pcrw_board u_board (.sys_clk, .pin_out(port_pin_out), .pin_oe(port_pin_oe),
		.pull_on(port_pull_on), .pin_in(port_pin_in), .ext_val(bd_val), .ext_en(bd_en));
	always #2 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// peripheral outputs wander at random
	always @(posedge sys_clk) begin
		{bus_out, bus_oe} <= rnd();
		{ctrl_fn_out, ctrl_fn_oe, timer_out, timer_oe} <= rnd();
		{serial_out, serial_oe, link_out, link_oe, pwm_chan_out[1:0]} <= rnd();
		pwm_chan_out[3:2] <= seed[9:8];
	end
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		s_axi_awaddr <= {a, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'h0;
		chk(40'({s_axi_bvalid, s_axi_bresp}), 40'({1'h1, er}));
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
		int n;
		s_axi_araddr <= {a, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'h0;
		chk({5'h0, s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {5'h0, 1'h1, er, 24'h0, e});
		@(posedge sys_clk);
	endtask
	task automatic stop_test();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'h1;
		serial_claim <= 8'h5A;
		link_enable <= 1'h1;
		repeat (8) @(posedge sys_clk);
		rd(16'h0002, 8'h00, 2'h0);
		rd(16'h0003, 8'h00, 2'h0);
		rd(16'h000C, 8'h10, 2'h0);
		rd(16'h0011, 8'h00, 2'h0);
		for (int i = 0; i < 10; i++) begin
			v = rnd();
			wr(ix[i], v, 2'h0);
			rd(ix[i], v & mk[i], 2'h0);
		end
		pwm_chan_en <= 4'hF;
		timer_claim <= 8'hFF;
		repeat (10) @(posedge sys_clk);
		chk(40'(port_pin_oe[27:24]), 40'hF);
		pwm_chan_en <= 4'h0;
		timer_claim <= 8'h00;
		for (int i = 0; i < 2; i++) begin
			v = rnd();
			wr(16'h0002 + 16'(i), 8'hFF, 2'h0);
			wr(16'(i), v, 2'h0);
			rd(16'(i), v, 2'h0);
			chk(40'(port_pin_out[8*i +: 8]), 40'(v));
		end
		wr(16'h0002, 8'h00, 2'h0);
		wr(16'h000C, 8'h00, 2'h0);
		v = rnd();
		bd_val <= {56'h0, v};
		bd_en <= 64'hFF;
		repeat (6) @(posedge sys_clk);
		rd(16'h0000, v, 2'h0);
		bd_en <= 64'h0;
		wr(16'h000C, 8'h01, 2'h0);
		repeat (6) @(posedge sys_clk);
		chk(40'(port_pull_on[7:0]), 40'hFF);
		rd(16'h0000, 8'hFF, 2'h0);
		wr(16'h000D, 8'h0B, 2'h0);
		wr(16'h000D, 8'h00, 2'h0);
		rd(16'h000D, 8'h0B, 2'h0);
		chk(40'(port_low_drive[23:0]), 40'hFFFFFF);
		rd(16'h0200, 8'h00, 2'h3);
		wr(16'h0011, 8'h08, 2'h0);
		rd(16'h0802, 8'h00, 2'h0);
		rd(16'h0002, 8'h00, 2'h3);
		wr(16'h0811, 8'h00, 2'h0);
		rd(16'h0011, 8'h00, 2'h0);
		nrst <= 1'h0;
		mode_pins <= 2'h1;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'h1;
		repeat (8) @(posedge sys_clk);
		chk(40'(op_mode_reg), 40'h1);
		rd(16'h0000, 8'h00, 2'h0);
		wr(16'h0002, 8'hFF, 2'h0);
		rd(16'h0002, 8'h00, 2'h0);
		wr(16'h000C, 8'h03, 2'h0);
		repeat (2) @(posedge sys_clk);
		chk(40'(port_pull_on[15:0]), 40'h0);
		stop_test();
	end
endmodule
bind pcrw_top pcrw_props #(.NPORT(NPORT), .PW(PW)) u_props (.sys_clk, .nrst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_araddr, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .port_pin_out, .port_pin_oe,
	.port_pull_on, .op_mode_reg, .bus_oe, .pwm_chan_en, .pwm_chan_out, .timer_claim, .timer_oe);
`default_nettype wire
